// [shared/dram_ctl_defines.svh]
// Timing and layout constants for the EDO DRAM controller.
// Assumes a 50 MHz core clock; cycle counts derive from nanosecond figures.
`ifndef DRAM_CTL_DEFINES_SVH
`define DRAM_CTL_DEFINES_SVH
`define CLK_PERIOD_NS       20
`define T_RAS_NS            60
`define T_RP_NS             40
`define T_RCD_NS            20
`define T_CAS_NS            15
`define T_CP_NS             10
`define T_PWRUP_US          200
`define T_REF_MS            8
`define REF_ROWS            512
`define INIT_CYCLES         8
`define CYC_UP(ns)          (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_RAS             `CYC_UP(`T_RAS_NS)
`define CYC_RP              `CYC_UP(`T_RP_NS)
`define CYC_RCD             `CYC_UP(`T_RCD_NS)
`define CYC_CAS             (`CYC_UP(`T_CAS_NS) + 1)
`define CYC_CP              `CYC_UP(`T_CP_NS)
`define CYC_PWRUP           ((`T_PWRUP_US * 1000) / `CLK_PERIOD_NS)
`define CYC_REF_INT         ((`T_REF_MS * 1000000) / `CLK_PERIOD_NS / `REF_ROWS)
`define ADDR_W              9
`define DATA_W              16
`define CNT_W               16
`endif

// [shared/dram_ctl_pkg.sv]
// Types shared by the EDO DRAM controller files.
// Assumes dram_ctl_defines.svh is on the include path.
`default_nettype none
`include "dram_ctl_defines.svh"
package dram_ctl_pkg;
  // Pin-side bundle driven toward the DRAM; strobes are active low.
  typedef struct packed {
    logic                 ras_n;
    logic                 lower_byte_col_strobe_n;
    logic                 upper_byte_col_strobe_n;
    logic                 we_n;
    logic                 oe_n;
    logic [`ADDR_W-1:0]   addr;
    logic [`DATA_W-1:0]   dq_out;
    logic                 dq_oe;
  } pins_t;
  // User request.
  typedef struct packed {
    logic                 write;
    logic [1:0]           byte_en;
    logic [`ADDR_W-1:0]   row;
    logic [`ADDR_W-1:0]   col;
    logic [`DATA_W-1:0]   wdata;
  } req_t;
  typedef enum logic [3:0] {
    S_PWRUP, S_IDLE, S_ROW, S_COL, S_CASH, S_CBR_CAS, S_CBR_RAS, S_PRE, S_INIT
  } state_t;
endpackage
`default_nettype wire

// [src/dram_timer.sv]
// Down-counter used for every minimum wait in the controller.
// Assumes loads come from logic on core_clk.
`timescale 1ns/100ps
`default_nettype none
module dram_timer #(
  parameter int W = 16
) (
  // Clock and reset.
  input  wire logic         core_clk,
  input  wire logic         sys_rst,
  // Load and status.
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  output logic              done
);
  // ==========================================================
  // Counter state
  typedef struct packed { logic [W-1:0] cnt; } tmr_t;
  tmr_t st_q, st_d;
  // Load wins over counting so a new wait always starts cleanly.
  always_comb begin
    st_d = st_q;
    if (load) begin
      st_d.cnt = value;
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - {{(W-1){1'b0}}, 1'b1};
    end
  end
  // A load during reset is kept, so the power-up wait starts from reset itself.
  always_ff @(posedge core_clk) begin
    if (sys_rst && !load) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  // Done is purely registered; gating it with load would close a loop through the caller.
  assign done = (st_q.cnt == '0);
endmodule
`default_nettype wire

// [src/edo_dram_ctl.sv]
// EDO DRAM controller: drives strobes, address and data of a 256K x 16 EDO part.
// Assumes the user side sits on core_clk; DRAM read data arrives on pins.
`timescale 1ns/100ps
`default_nettype none
`include "dram_ctl_defines.svh"
module edo_dram_ctl #(
  parameter int PWRUP_CYCLES = `CYC_PWRUP,
  parameter int REF_INTERVAL = `CYC_REF_INT
) (
  // Clock and reset.
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  // User request side.
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire dram_ctl_pkg::req_t   req,
  input  wire logic                 req_last,
  output logic                      rd_valid,
  output logic [`DATA_W-1:0]        rd_data,
  output logic                      init_done,
  input  wire logic                 refresh_lapsed,
  // DRAM pins.
  output dram_ctl_pkg::pins_t       pins,
  input  wire logic [`DATA_W-1:0]   dq_in
);
  // ==========================================================
  // State record
  typedef struct packed {
    dram_ctl_pkg::state_t state;
    dram_ctl_pkg::pins_t  pins;
    logic [`ADDR_W-1:0]   open_row;
    logic                 row_open;
    logic                 cur_write;
    logic [3:0]           init_cnt;
    logic [`CNT_W-1:0]    ref_cnt;
    logic                 ref_due;
    logic                 rd_pend;
    logic                 rd_valid;
    logic [`DATA_W-1:0]   rd_data;
    logic                 init_done;
    logic [`DATA_W-1:0]   dq_s1;
    logic [`DATA_W-1:0]   dq_s2;
  } st_t;
  st_t st_q, st_d;
  logic              tmr_load;
  logic [`CNT_W-1:0] tmr_val;
  logic              tmr_done;
  logic              ras_load;
  logic              ras_done;
  logic              start_ok;

  // ==========================================================
  // Timers: one general wait and one guarding the RAS low width.
  dram_timer #(.W(`CNT_W)) u_tmr (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (tmr_load),
    .value    (tmr_val),
    .done     (tmr_done)
  );
  dram_timer #(.W(`CNT_W)) u_ras (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .load     (ras_load),
    .value    (`CNT_W'(`CYC_RAS - 1)),
    .done     (ras_done)
  );

  // ==========================================================
  // Next-state logic.
  always_comb begin
    st_d     = st_q;
    tmr_load = 1'b0;
    tmr_val  = '0;
    ras_load = 1'b0;
    st_d.rd_valid = 1'b0;
    // Read data comes from another domain, so it is double flopped first.
    st_d.dq_s1 = dq_in;
    st_d.dq_s2 = st_q.dq_s1;
    // Refresh pacing spreads 512 rows evenly over the retention period.
    if (st_q.ref_cnt == '0) begin
      st_d.ref_cnt = `CNT_W'(REF_INTERVAL - 1);
      st_d.ref_due = 1'b1;
    end else begin
      st_d.ref_cnt = st_q.ref_cnt - `CNT_W'(1);
    end
    start_ok = tmr_done;
    case (st_q.state)
      dram_ctl_pkg::S_PWRUP: begin
        if (tmr_done) begin
          st_d.state = dram_ctl_pkg::S_IDLE;
        end
      end
      dram_ctl_pkg::S_IDLE: begin
        if (start_ok && (st_q.init_cnt != '0 || st_q.ref_due)) begin
          // Byte strobes low before RAS falls selects counter refresh.
          st_d.pins.lower_byte_col_strobe_n = 1'b0;
          st_d.pins.upper_byte_col_strobe_n = 1'b0;
          st_d.pins.dq_oe = 1'b0;
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(`CYC_CP);
          st_d.state = dram_ctl_pkg::S_CBR_CAS;
        end else if (start_ok && req_valid && st_q.init_done) begin
          st_d.pins.addr  = req.row;
          st_d.pins.ras_n = 1'b0;
          st_d.open_row   = req.row;
          st_d.row_open   = 1'b1;
          ras_load = 1'b1;
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(`CYC_RCD);
          st_d.state = dram_ctl_pkg::S_ROW;
        end
      end
      dram_ctl_pkg::S_ROW, dram_ctl_pkg::S_CASH: begin
        if (tmr_done && req_valid) begin
          st_d.pins.addr = req.col;
          st_d.cur_write = req.write;
          st_d.pins.we_n = !req.write;
          st_d.pins.oe_n = req.write;
          st_d.pins.dq_out = req.wdata;
          st_d.pins.dq_oe  = req.write;
          st_d.state = dram_ctl_pkg::S_COL;
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(1);
        end else if (tmr_done && st_q.state == dram_ctl_pkg::S_CASH) begin
          st_d.state = dram_ctl_pkg::S_PRE;
        end
      end
      dram_ctl_pkg::S_COL: begin
        // Strobes fall one cycle after address, data and WE settle.
        if (st_q.pins.lower_byte_col_strobe_n && st_q.pins.upper_byte_col_strobe_n) begin
          st_d.pins.lower_byte_col_strobe_n = !req.byte_en[0];
          st_d.pins.upper_byte_col_strobe_n = !req.byte_en[1];
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(`CYC_CAS);
          st_d.rd_pend = !st_q.cur_write;
        end else if (tmr_done) begin
          // Column stays on the pins until the strobes rise.
          st_d.pins.lower_byte_col_strobe_n = 1'b1;
          st_d.pins.upper_byte_col_strobe_n = 1'b1;
          st_d.pins.we_n  = 1'b1;
          st_d.pins.dq_oe = 1'b0;
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(`CYC_CP);
          st_d.state = req_last ? dram_ctl_pkg::S_PRE : dram_ctl_pkg::S_CASH;
        end
        // EDO keeps data after CAS rises, so sampling late is still safe.
        if (st_q.rd_pend && tmr_done) begin
          st_d.rd_pend  = 1'b0;
          st_d.rd_valid = 1'b1;
          st_d.rd_data  = st_q.dq_s2;
        end
      end
      dram_ctl_pkg::S_PRE: begin
        if (ras_done && tmr_done) begin
          st_d.pins.ras_n = 1'b1;
          st_d.pins.oe_n  = 1'b1;
          st_d.row_open   = 1'b0;
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(`CYC_RP);
          st_d.state = dram_ctl_pkg::S_IDLE;
        end
      end
      dram_ctl_pkg::S_CBR_CAS: begin
        if (tmr_done) begin
          // Address pins are don't-care; the part counts rows itself.
          st_d.pins.ras_n = 1'b0;
          ras_load = 1'b1;
          st_d.state = dram_ctl_pkg::S_CBR_RAS;
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(1);
        end
      end
      dram_ctl_pkg::S_CBR_RAS: begin
        if (tmr_done) begin
          st_d.pins.lower_byte_col_strobe_n = 1'b1;
          st_d.pins.upper_byte_col_strobe_n = 1'b1;
          tmr_load = 1'b1;
          tmr_val  = `CNT_W'(1);
          st_d.state = dram_ctl_pkg::S_PRE;
          if (st_q.init_cnt != '0) begin
            st_d.init_cnt = st_q.init_cnt - 4'(1);
            if (st_q.init_cnt == 4'(1)) begin
              st_d.init_done = !refresh_lapsed;
            end
          end else begin
            st_d.ref_due = (st_q.ref_cnt == '0);
          end
        end
      end
      default: begin
        st_d.state = dram_ctl_pkg::S_IDLE;
      end
    endcase
    // A lapse wins over a wake cycle that finishes in the same clock.
    if (refresh_lapsed) begin
      st_d.init_cnt  = 4'(`INIT_CYCLES);
      st_d.init_done = 1'b0;
    end
    if (sys_rst) begin
      tmr_load = 1'b1;
      tmr_val  = `CNT_W'(PWRUP_CYCLES);
    end
  end

  // ==========================================================
  // State register.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q <= '0;
      st_q.state <= dram_ctl_pkg::S_PWRUP;
      st_q.pins.ras_n <= 1'b1;
      st_q.pins.lower_byte_col_strobe_n <= 1'b1;
      st_q.pins.upper_byte_col_strobe_n <= 1'b1;
      st_q.pins.we_n <= 1'b1;
      st_q.pins.oe_n <= 1'b1;
      st_q.init_cnt <= 4'(`INIT_CYCLES);
      st_q.ref_cnt <= `CNT_W'(REF_INTERVAL - 1);
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // Outputs.
  assign pins      = st_q.pins;
  assign rd_valid  = st_q.rd_valid;
  assign rd_data   = st_q.rd_data;
  assign init_done = st_q.init_done;
  assign req_ready = tmr_done && req_valid &&
                     (st_q.state == dram_ctl_pkg::S_ROW || st_q.state == dram_ctl_pkg::S_CASH);
endmodule
`default_nettype wire

// [sim/edo_dram_ctl_chk.sv]
// Checker for the EDO DRAM controller pin protocol.
// Assumes it is bound to edo_dram_ctl and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module edo_dram_ctl_chk (
  // Clock and reset.
  input wire logic                core_clk,
  input wire logic                sys_rst,
  // Observed ports.
  input wire logic                req_ready,
  input wire logic                rd_valid,
  input wire logic                init_done,
  input wire logic                refresh_lapsed,
  input wire dram_ctl_pkg::pins_t pins
);
  // ==========================================================
  // Protocol properties
  // Internal CAS is active while either byte strobe is low.
  logic cas_on;
  assign cas_on = !pins.lower_byte_col_strobe_n || !pins.upper_byte_col_strobe_n;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_read_start; $rose(cas_on) && !pins.oe_n && !pins.ras_n; endsequence
  sequence s_cbr_start; $fell(pins.ras_n) && cas_on; endsequence
  a_reset_idle: assert property (disable iff (1'b0) sys_rst |=> pins.ras_n && !cas_on && !pins.dq_oe && !init_done)
    else $error("pins not idle after reset");
  a_ras_width: assert property ($fell(pins.ras_n) |-> !pins.ras_n [*3])
    else $error("row strobe pulse too short");
  a_ras_precharge: assert property ($rose(pins.ras_n) |-> pins.ras_n [*2])
    else $error("row precharge too short");
  a_read_we_high: assert property (cas_on && !pins.oe_n |-> pins.we_n)
    else $error("write enable low during read");
  a_col_hold: assert property (cas_on && $past(cas_on) && !pins.ras_n && !pins.oe_n |-> $stable(pins.addr))
    else $error("column address moved during read");
  a_read_answer: assert property (s_read_start |-> ##[1:8] rd_valid)
    else $error("read data never returned");
  a_write_data: assert property ($rose(cas_on) && !pins.we_n |-> pins.dq_oe && $stable(pins.dq_out))
    else $error("write data late");
  a_cbr_hold: assert property (s_cbr_start |=> cas_on)
    else $error("strobe released early in refresh");
  a_cbr_quiet: assert property (s_cbr_start |-> !pins.dq_oe [*3])
    else $error("data driven during refresh");
  a_ready_init: assert property (req_ready |-> init_done)
    else $error("request taken before wake-up");
  a_lapse_drop: assert property (refresh_lapsed |-> ##[1:2] !init_done)
    else $error("ready kept after refresh lapse");
endmodule
`default_nettype wire

// [sim/dram_dev_model.sv]
// Behavioural model of the EDO DRAM seen at the controller's pins.
// Assumes registered strobes from the controller; the array is sparse.
`timescale 1ns/100ps
`default_nettype none
module dram_dev_model #(
  parameter int ACC_NS = 5
) (
  // Pins from the controller.
  input  wire dram_ctl_pkg::pins_t pins,
  // Read data and refresh tally.
  output logic [15:0]              dq_in,
  output int                       cbr_count
);
  // ==========================================================
  // Array and cycle state
  logic [15:0] mem [int];
  logic [8:0]  row_q;
  logic [8:0]  row_ctr;
  logic [15:0] rdata;
  logic [1:0]  drv;
  logic        cbr;
  int          k;
  wire         cas_on = !pins.lower_byte_col_strobe_n || !pins.upper_byte_col_strobe_n;
  initial begin
    cbr_count = 0;
    row_ctr = 9'h000;
    drv = 2'b00;
    cbr = 1'b0;
    rdata = 16'h0000;
  end
  // The RAS fall opens a row, or a refresh when CAS is already low.
  always @(negedge pins.ras_n) begin
    cbr = cas_on;
    if (cas_on) begin
      cbr_count++;
      row_ctr++;
    end else begin
      row_q = pins.addr;
    end
  end
  // The RAS rise ends the cycle and floats the outputs.
  always @(posedge pins.ras_n) begin
    drv = 2'b00;
    cbr = 1'b0;
  end
  // Each CAS fall is one column access; refresh cycles touch no data.
  always @(posedge cas_on) if (!pins.ras_n && !cbr) begin
    k = {row_q, pins.addr};
    drv = 2'b00;
    if (!mem.exists(k)) mem[k] = 16'h0000;
    if (!pins.we_n) begin
      if (!pins.lower_byte_col_strobe_n) mem[k][7:0] = pins.dq_out[7:0];
      if (!pins.upper_byte_col_strobe_n) mem[k][15:8] = pins.dq_out[15:8];
    end else begin
      #(ACC_NS);
      rdata = mem[k];
      drv = {!pins.upper_byte_col_strobe_n, !pins.lower_byte_col_strobe_n};
    end
  end
  // A floating byte shows the inverse of its last value, never stale data.
  assign dq_in[7:0] = (drv[0] && !pins.oe_n) ? rdata[7:0] : ~rdata[7:0];
  assign dq_in[15:8] = (drv[1] && !pins.oe_n) ? rdata[15:8] : ~rdata[15:8];
endmodule
`default_nettype wire

// [sim/tb_edo_dram_ctl.sv]
// Self-checking bench for the EDO DRAM controller with a device model.
// Assumes the package, defines header and checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_edo_dram_ctl;
  localparam int REF_INT = 200;
  logic core_clk, sys_rst, req_valid, req_last, refresh_lapsed;
  logic req_ready, rd_valid, init_done;
  logic [15:0] rd_data, dq_in;
  dram_ctl_pkg::req_t req;
  dram_ctl_pkg::pins_t pins;
  int cbr_count, err_total, comparisons;
  edo_dram_ctl #(.PWRUP_CYCLES(20), .REF_INTERVAL(REF_INT)) u_edo_dram_ctl (
    .core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_ready(req_ready),
    .req(req), .req_last(req_last), .rd_valid(rd_valid), .rd_data(rd_data),
    .init_done(init_done), .refresh_lapsed(refresh_lapsed), .pins(pins), .dq_in(dq_in));
  dram_dev_model u_dram_dev_model (.pins(pins), .dq_in(dq_in), .cbr_count(cbr_count));
  // ==========================================================
  // Clock and shared tasks
  always #10 core_clk = ~core_clk;
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Sampled on falling edges so registered outputs have settled.
  task automatic wait_for(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      if ((sel == 0 ? req_ready : sel == 1 ? rd_valid : init_done) === 1'b1) return;
    end
    err_total++;
    $display("CHECK FAILED wait %0d expected 1 seen timeout", sel);
    end_of_test();
  endtask
  // One column access; a read compares its data with d.
  task automatic access(input logic wr, input logic [1:0] be, input logic [8:0] r,
                        input logic [8:0] c, input logic [15:0] d, input logic last);
    @(negedge core_clk);
    req = '{wr, be, r, c, d};
    req_valid = 1'b1;
    req_last = last;
    wait_for(0, 400);
    @(negedge core_clk);
    req_valid = 1'b0;
    if (!wr) begin
      wait_for(1, 50);
      chk("read data", d, rd_data);
    end
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_reset();
    repeat (3) @(negedge core_clk);
    chk("idle strobes", 16'h0007, {13'h0, pins.ras_n, pins.lower_byte_col_strobe_n,
        pins.upper_byte_col_strobe_n});
    chk("reset outputs", 16'h0000, {14'h0, pins.dq_oe, init_done});
    @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (10) @(negedge core_clk);
    chk("power-up row strobe", 16'h0001, {15'h0, pins.ras_n});
    chk("power-up refreshes", 16'h0000, 16'(cbr_count));
    wait_for(2, 3000);
    chk("wake refreshes", 16'h0001, {15'h0, cbr_count >= 8});
    $display("test reset done");
  endtask
  task automatic t_page();
    access(1'b1, 2'b11, 9'h1ff, 9'h000, 16'h1234, 1'b0);
    access(1'b1, 2'b11, 9'h1ff, 9'h1ff, 16'h5678, 1'b0);
    access(1'b0, 2'b11, 9'h1ff, 9'h000, 16'h1234, 1'b0);
    access(1'b0, 2'b11, 9'h1ff, 9'h1ff, 16'h5678, 1'b1);
    $display("test page done");
  endtask
  task automatic t_bytes();
    access(1'b1, 2'b11, 9'h005, 9'h003, 16'ha5c3, 1'b1);
    access(1'b0, 2'b11, 9'h005, 9'h003, 16'ha5c3, 1'b1);
    access(1'b1, 2'b01, 9'h005, 9'h003, 16'h0011, 1'b1);
    access(1'b0, 2'b11, 9'h005, 9'h003, 16'ha511, 1'b1);
    access(1'b1, 2'b10, 9'h005, 9'h003, 16'h7700, 1'b1);
    access(1'b0, 2'b11, 9'h005, 9'h003, 16'h7711, 1'b1);
    $display("test bytes done");
  endtask
  task automatic t_refresh();
    int c0;
    c0 = cbr_count;
    repeat (3 * REF_INT) @(negedge core_clk);
    chk("periodic refresh", 16'h0001, {15'h0, cbr_count >= c0 + 2});
    c0 = cbr_count;
    refresh_lapsed = 1'b1;
    @(negedge core_clk);
    refresh_lapsed = 1'b0;
    repeat (2) @(negedge core_clk);
    chk("ready after lapse", 16'h0000, {15'h0, init_done});
    wait_for(2, 3000);
    chk("lapse refreshes", 16'h0001, {15'h0, cbr_count >= c0 + 8});
    access(1'b0, 2'b11, 9'h005, 9'h003, 16'h7711, 1'b1);
    $display("test refresh done");
  endtask
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_last = 1'b0;
    refresh_lapsed = 1'b0;
    req = '0;
    err_total = 0;
    comparisons = 0;
    t_reset();
    t_page();
    t_bytes();
    t_refresh();
    end_of_test();
  end
endmodule
bind edo_dram_ctl edo_dram_ctl_chk u_edo_dram_ctl_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .req_ready(req_ready), .rd_valid(rd_valid),
  .init_done(init_done), .refresh_lapsed(refresh_lapsed), .pins(pins));
`default_nettype wire
